// *** rtl/fsq_top.v ***
// fsq_top.v: flash block program sequencer with double-buffered staging
`timescale 1ns/1ps
`default_nettype none
`include "fsq_regs.vh"
module fsq_top (
  // clock, reset, enable
  input  wire        CLK_I,
  input  wire        RESET_I,
  input  wire        CE_I,
  // mode strap pins
  input  wire        FLASH_WRITE_ENABLE_STRAP_I,
  input  wire        MODE_STRAP_ONE_I,
  input  wire        MODE_STRAP_ZERO_I,
  // working ram port
  input  wire        SEQUENCER_RAM_ENABLE_REG_I,
  input  wire        RAM_WE_I,
  input  wire [3:0]  RAM_ADDR_I,
  input  wire [15:0] RAM_WDATA_I,
  output reg  [15:0] RAM_RDATA_O,
  // processor command writes
  input  wire        CMD_VALID_I,
  input  wire [31:0] CMD_ADDR_I,
  input  wire [15:0] CMD_DATA_I,
  input  wire        CMD_WORD_I,
  input  wire        CMD_ERR_CLR_I,
  // external device jobs
  input  wire        JOB_ERASE_I,
  input  wire [7:0]  ERASE_FIRST_I,
  input  wire [7:0]  ERASE_COUNT_I,
  input  wire        JOB_PROG_I,
  input  wire [31:0] WR_START_I,
  input  wire [31:0] WR_COUNT_I,
  // download stream
  input  wire        DL_VALID_I,
  input  wire [15:0] DL_DATA_I,
  output wire        DL_READY_O,
  // staging buffer configuration and read
  input  wire        BUF_BASE_WE_I,
  input  wire [31:0] BUF_A_BASE_I,
  input  wire [31:0] BUF_B_BASE_I,
  input  wire [31:0] BUF_RD_ADDR_I,
  output reg  [15:0] BUF_RD_DATA_O,
  // flash array port
  input  wire        FL_DONE_I,
  output reg         FL_ERASE_O,
  output reg         FL_LOAD_O,
  output reg         FL_PROG_O,
  output reg  [19:0] FL_ADDR_O,
  output reg  [15:0] FL_DATA_O,
  // status
  output reg         BUSY_O,
  output reg         CMD_ERR_O,
  output reg         USER_MODE_O,
  output reg         FW_READY_O,
  output reg         STAGE_SEL_O,
  output reg  [1:0]  STAGE_FULL_O,
  output reg         JOB_DONE_O
);
  localparam [2:0] S_IDLE = 3'd0, S_ERA_ARM = 3'd1, S_PRG_SIZE = 3'd2,
                   S_PRG_DATA = 3'd3, S_WAIT = 3'd4, S_JOB_ERA = 3'd5,
                   S_JOB_PICK = 3'd6, S_JOB_LOAD = 3'd7;

  function in_alias;
    input [31:0] a;
    reg   [31:0] d;
    begin
      d        = a - `FSQ_ALIAS_OFS;
      in_alias = (a >= `FSQ_ALIAS_OFS) && (d < `FSQ_ARRAY_BYTES);
    end
  endfunction

  function [4:0] block_of;
    input [19:0] fa;
    reg   [19:0] off;
    begin
      off = fa - `FSQ_BIG_START;
      if (fa < `FSQ_MID_START)
        block_of = {2'b00, fa[15:13]};
      else if (fa < `FSQ_BIG_START)
        block_of = 5'h07 + {1'b0, fa[19:16]};
      else
        block_of = `FSQ_BIG_FIRST + {2'b00, off[19:17]};
    end
  endfunction

  function [19:0] block_base;
    input [4:0] b;
    reg   [4:0] k;
    begin
      k = 5'h00;
      if (b < `FSQ_SMALL_BLKS) begin
        block_base = {7'h00, b, 8'h00} << 5;
      end else if (b < `FSQ_BIG_FIRST) begin
        k          = b - 5'h07;
        block_base = {k[3:0], 16'h0000};
      end else begin
        k          = b - `FSQ_BIG_FIRST;
        block_base = `FSQ_BIG_START + {k[2:0], 17'h0_0000};
      end
    end
  endfunction

  reg  [2:0]  sync1_q, sync2_q;
  reg  [15:0] fw_q [0:15];
  reg  [2:0]  state_q;
  reg  [6:0]  widx_q;
  reg  [19:0] page_q;
  reg  [19:0] job_addr_q;
  reg  [31:0] job_left_q;
  reg  [4:0]  blk_q;
  reg  [7:0]  era_left_q;
  reg         job_era_q, job_prg_q, prg_act_q;
  reg  [6:0]  dl_idx_q;
  reg  [31:0] base_a_q, base_b_q;
  wire        user_mode = sync2_q[2] & sync2_q[1] & ~sync2_q[0];
  wire [31:0] fa32 = CMD_ADDR_I - `FSQ_ALIAS_OFS;
  wire [19:0] fa = fa32[19:0];
  wire        cmd_ok = CMD_VALID_I & CMD_WORD_I & in_alias(CMD_ADDR_I);
  wire        pe_ok = user_mode & FW_READY_O;
  wire        dl_bank = ~STAGE_SEL_O;
  wire        fifo_valid;
  wire [15:0] fifo_data;
  wire        fifo_take = ~STAGE_FULL_O[dl_bank];
  wire        dl_push = fifo_valid & fifo_take;
  wire [15:0] pg_data, cpu_data;
  wire [31:0] rd_a = BUF_RD_ADDR_I - base_a_q;
  wire [31:0] rd_b = BUF_RD_ADDR_I - base_b_q;
  wire        hit_a = (BUF_RD_ADDR_I >= base_a_q) && (rd_a < `FSQ_BUF_SPAN);
  wire        hit_b = (BUF_RD_ADDR_I >= base_b_q) && (rd_b < `FSQ_BUF_SPAN);
  wire [6:0]  cpu_idx = hit_a ? rd_a[7:1] : rd_b[7:1];
  reg         err_set;

  fsq_fifo #(.W(16), .D(4), .AW(2)) u_fifo (
    .clk_i      (CLK_I),
    .rst_i      (RESET_I),
    .ce_i       (CE_I),
    .in_valid_i (DL_VALID_I),
    .in_ready_o (DL_READY_O),
    .in_data_i  (DL_DATA_I),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_take),
    .out_data_o (fifo_data)
  );

  fsq_stage_buf u_stage (
    .clk_i     (CLK_I),
    .ce_i      (CE_I),
    .wr_en_i   (dl_push),
    .wr_bank_i (dl_bank),
    .wr_idx_i  (dl_idx_q),
    .wr_data_i (fifo_data),
    .pg_bank_i (STAGE_SEL_O),
    .pg_idx_i  (widx_q),
    .pg_data_o (pg_data),
    .cpu_bank_i(~hit_a),
    .cpu_idx_i (cpu_idx),
    .cpu_data_o(cpu_data)
  );

  // strap synchroniser and mode decode
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      sync1_q     <= 3'h0;
      sync2_q     <= 3'h0;
      USER_MODE_O <= 1'b0;
    end else if (CE_I) begin
      sync1_q     <= {FLASH_WRITE_ENABLE_STRAP_I, MODE_STRAP_ONE_I,
                      MODE_STRAP_ZERO_I};
      sync2_q     <= sync1_q;
      USER_MODE_O <= user_mode;
    end
  end

  // working ram, gated by the enable bit
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      RAM_RDATA_O <= 16'h0000;
      FW_READY_O  <= 1'b0;
    end else if (CE_I) begin
      RAM_RDATA_O <= SEQUENCER_RAM_ENABLE_REG_I ? fw_q[RAM_ADDR_I]
                                                : 16'h0000;
      if (SEQUENCER_RAM_ENABLE_REG_I && RAM_WE_I) begin
        fw_q[RAM_ADDR_I] <= RAM_WDATA_I;
        if (RAM_ADDR_I == `FSQ_FW_LAST)
          FW_READY_O <= 1'b1;
      end
    end
  end

  // staging: download side, role flag, relocatable bases
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      dl_idx_q      <= 7'h00;
      STAGE_FULL_O  <= 2'b00;
      STAGE_SEL_O   <= 1'b0;
      base_a_q      <= `FSQ_BUF_A_RST;
      base_b_q      <= `FSQ_BUF_B_RST;
      BUF_RD_DATA_O <= 16'h0000;
    end else if (CE_I) begin
      if (BUF_BASE_WE_I) begin
        base_a_q <= BUF_A_BASE_I;
        base_b_q <= BUF_B_BASE_I;
      end
      BUF_RD_DATA_O <= (hit_a | hit_b) ? cpu_data : 16'h0000;
      if (state_q == S_WAIT && FL_DONE_I && prg_act_q)
        STAGE_FULL_O[STAGE_SEL_O] <= 1'b0;
      if (dl_push) begin
        dl_idx_q <= dl_idx_q + 7'h01;
        if (dl_idx_q == 7'h7F)
          STAGE_FULL_O[dl_bank] <= 1'b1;
      end
      if (!prg_act_q && !STAGE_FULL_O[STAGE_SEL_O] &&
          STAGE_FULL_O[dl_bank])
        STAGE_SEL_O <= ~STAGE_SEL_O;
    end
  end

  // command and job sequencer
  always @* begin
    err_set = 1'b0;
    if (CMD_VALID_I && !cmd_ok)
      err_set = 1'b1;
    else if (cmd_ok && (BUSY_O || !pe_ok ||
             (state_q != S_IDLE && state_q != S_ERA_ARM &&
              state_q != S_PRG_SIZE && state_q != S_PRG_DATA)))
      err_set = 1'b1;
    else if (cmd_ok && state_q == S_PRG_SIZE &&
             CMD_DATA_I[7:0] != `FSQ_SIZE_CODE)
      err_set = 1'b1;
    else if (cmd_ok && state_q == S_ERA_ARM &&
             CMD_DATA_I[7:0] != `FSQ_CMD_EXEC)
      err_set = 1'b1;
    else if (cmd_ok && state_q == S_IDLE &&
             CMD_DATA_I[7:0] != `FSQ_CMD_ERASE &&
             CMD_DATA_I[7:0] != `FSQ_CMD_PROG)
      err_set = 1'b1;
  end

  always @(posedge CLK_I) begin
    if (RESET_I) begin
      state_q    <= S_IDLE;
      widx_q     <= 7'h00;
      page_q     <= 20'h0_0000;
      job_addr_q <= 20'h0_0000;
      job_left_q <= 32'h0000_0000;
      blk_q      <= 5'h00;
      era_left_q <= 8'h00;
      job_era_q  <= 1'b0;
      job_prg_q  <= 1'b0;
      prg_act_q  <= 1'b0;
      FL_ERASE_O <= 1'b0;
      FL_LOAD_O  <= 1'b0;
      FL_PROG_O  <= 1'b0;
      FL_ADDR_O  <= 20'h0_0000;
      FL_DATA_O  <= 16'h0000;
      BUSY_O     <= 1'b0;
      CMD_ERR_O  <= 1'b0;
      JOB_DONE_O <= 1'b0;
    end else if (CE_I) begin
      FL_ERASE_O <= 1'b0;
      FL_LOAD_O  <= 1'b0;
      FL_PROG_O  <= 1'b0;
      JOB_DONE_O <= 1'b0;
      if (err_set)
        CMD_ERR_O <= 1'b1;
      else if (CMD_ERR_CLR_I)
        CMD_ERR_O <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (cmd_ok && !err_set) begin
            if (CMD_DATA_I[7:0] == `FSQ_CMD_ERASE)
              state_q <= S_ERA_ARM;
            else
              state_q <= S_PRG_SIZE;
          end else if (JOB_ERASE_I && pe_ok) begin
            job_era_q  <= 1'b1;
            blk_q      <= ERASE_FIRST_I[4:0];
            era_left_q <= (ERASE_FIRST_I > {3'h0, `FSQ_LAST_BLK}) ?
                          8'h00 : ERASE_COUNT_I;
            BUSY_O     <= 1'b1;
            state_q    <= S_JOB_ERA;
          end else if (JOB_PROG_I && pe_ok) begin
            job_prg_q  <= 1'b1;
            job_addr_q <= {WR_START_I[19:8], 8'h00};
            job_left_q <= WR_COUNT_I;
            BUSY_O     <= 1'b1;
            state_q    <= S_JOB_PICK;
          end
        end
        S_ERA_ARM: begin
          if (cmd_ok && !err_set) begin
            FL_ERASE_O <= 1'b1;
            FL_ADDR_O  <= block_base(block_of(fa));
            BUSY_O     <= 1'b1;
            state_q    <= S_WAIT;
          end else if (err_set) begin
            state_q <= S_IDLE;
          end
        end
        S_PRG_SIZE: begin
          if (cmd_ok) begin
            widx_q  <= 7'h00;
            state_q <= err_set ? S_IDLE : S_PRG_DATA;
          end
        end
        S_PRG_DATA: begin
          if (err_set) begin
            state_q <= S_IDLE;
          end else if (cmd_ok) begin
            if (widx_q == 7'h00)
              page_q <= {fa[19:8], 8'h00};
            FL_LOAD_O <= 1'b1;
            FL_ADDR_O <= fa;
            FL_DATA_O <= CMD_DATA_I;
            widx_q    <= widx_q + 7'h01;
            if (widx_q == 7'h7F) begin
              state_q <= S_JOB_LOAD;
              BUSY_O  <= 1'b1;
            end
          end
        end
        S_JOB_LOAD: begin
          if (!job_prg_q) begin
            FL_PROG_O <= 1'b1;
            FL_ADDR_O <= page_q;
            state_q   <= S_WAIT;
          end else begin
            FL_LOAD_O <= 1'b1;
            FL_ADDR_O <= job_addr_q | {12'h000, widx_q, 1'b0};
            FL_DATA_O <= pg_data;
            widx_q    <= widx_q + 7'h01;
            if (widx_q == 7'h7F) begin
              state_q   <= S_JOB_PICK;
              prg_act_q <= 1'b1;
            end
          end
        end
        S_JOB_PICK: begin
          if (prg_act_q) begin
            FL_PROG_O <= 1'b1;
            FL_ADDR_O <= job_addr_q;
            state_q   <= S_WAIT;
          end else if (job_left_q == 32'h0000_0000) begin
            job_prg_q  <= 1'b0;
            BUSY_O     <= 1'b0;
            JOB_DONE_O <= 1'b1;
            state_q    <= S_IDLE;
          end else if (STAGE_FULL_O[STAGE_SEL_O]) begin
            widx_q  <= 7'h00;
            state_q <= S_JOB_LOAD;
          end
        end
        S_JOB_ERA: begin
          if (era_left_q == 8'h00 || blk_q > `FSQ_LAST_BLK) begin
            job_era_q  <= 1'b0;
            BUSY_O     <= 1'b0;
            JOB_DONE_O <= 1'b1;
            state_q    <= S_IDLE;
          end else begin
            FL_ERASE_O <= 1'b1;
            FL_ADDR_O  <= block_base(blk_q);
            blk_q      <= blk_q + 5'h01;
            era_left_q <= era_left_q - 8'h01;
            state_q    <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (FL_DONE_I) begin
            if (job_era_q) begin
              state_q <= S_JOB_ERA;
            end else if (job_prg_q) begin
              prg_act_q  <= 1'b0;
              job_addr_q <= job_addr_q + `FSQ_PAGE_STEP;
              job_left_q <= job_left_q - 32'h0000_0001;
              state_q    <= S_JOB_PICK;
            end else begin
              BUSY_O  <= 1'b0;
              state_q <= S_IDLE;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // fsq_top
`default_nettype wire

// *** rtl/fsq_regs.vh ***
// fsq_regs.vh: constants of the flash block program sequencer
`ifndef FSQ_REGS_VH
`define FSQ_REGS_VH

// alias window and array size
`define FSQ_ALIAS_OFS    32'h8080_0000
`define FSQ_ARRAY_BYTES  32'h0010_0000
// erase block map boundaries
`define FSQ_MID_START    20'h1_0000
`define FSQ_BIG_START    20'hA_0000
`define FSQ_SMALL_SHIFT  13
`define FSQ_MID_SHIFT    16
`define FSQ_BIG_SHIFT    17
`define FSQ_SMALL_BLKS   5'h08
`define FSQ_BIG_FIRST    5'h11
`define FSQ_LAST_BLK     5'h13
// sequencer command codes
`define FSQ_CMD_ERASE    8'h20
`define FSQ_CMD_EXEC     8'hD0
`define FSQ_CMD_PROG     8'hE8
`define FSQ_SIZE_CODE    8'h80
// page and staging geometry
`define FSQ_PAGE_WORDS   8'h80
`define FSQ_PAGE_STEP    20'h0_0100
`define FSQ_BUF_A_RST    32'hFFF8_1000
`define FSQ_BUF_B_RST    32'hFFF8_1100
`define FSQ_BUF_SPAN     32'h0000_0100
// sequencer working ram
`define FSQ_FW_WORDS     5'h10
`define FSQ_FW_LAST      4'hF

`endif

// *** rtl/fsq_fifo.v ***
// fsq_fifo.v: small flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module fsq_fifo #(
  parameter W  = 16,
  parameter D  = 4,
  parameter AW = 2
) (
  // clock and control
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         ce_i,
  // fill side
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  // drain side
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0]  mem_q [0:D-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0]   cnt_q;
  reg          rdy_q;
  reg          empty_q;
  wire         push = in_valid_i & rdy_q;
  wire         pop  = out_ready_i & ~empty_q;
  wire [AW:0]  cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign in_ready_o  = rdy_q;
  assign out_valid_o = ~empty_q;
  assign out_data_o  = mem_q[rd_q];

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_q    <= {AW{1'b0}};
      rd_q    <= {AW{1'b0}};
      cnt_q   <= {(AW+1){1'b0}};
      rdy_q   <= 1'b1;
      empty_q <= 1'b1;
    end else if (ce_i) begin
      if (push) begin
        mem_q[wr_q] <= in_data_i;
        wr_q        <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop)
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      cnt_q   <= cnt_d;
      rdy_q   <= (cnt_d != D[AW:0]);
      empty_q <= (cnt_d == {(AW+1){1'b0}});
    end
  end
endmodule // fsq_fifo
`default_nettype wire

// *** rtl/fsq_stage_buf.v ***
// fsq_stage_buf.v: two 256-byte staging banks, one write and two read ports
`timescale 1ns/1ps
`default_nettype none
module fsq_stage_buf (
  // clock and control
  input  wire        clk_i,
  input  wire        ce_i,
  // download write port
  input  wire        wr_en_i,
  input  wire        wr_bank_i,
  input  wire [6:0]  wr_idx_i,
  input  wire [15:0] wr_data_i,
  // program read port
  input  wire        pg_bank_i,
  input  wire [6:0]  pg_idx_i,
  output wire [15:0] pg_data_o,
  // processor read port
  input  wire        cpu_bank_i,
  input  wire [6:0]  cpu_idx_i,
  output wire [15:0] cpu_data_o
);
  reg [15:0] mem_q [0:255];

  assign pg_data_o  = mem_q[{pg_bank_i, pg_idx_i}];
  assign cpu_data_o = mem_q[{cpu_bank_i, cpu_idx_i}];

  always @(posedge clk_i) begin
    if (ce_i && wr_en_i)
      mem_q[{wr_bank_i, wr_idx_i}] <= wr_data_i;
  end
endmodule // fsq_stage_buf
`default_nettype wire

// *** bench/fsq_monitor.sv ***
// fsq_monitor.sv: port assertions for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module fsq_monitor (
  // clock and reset
  input wire logic        CLK_I,
  input wire logic        RESET_I,
  // straps and working ram
  input wire logic        FLASH_WRITE_ENABLE_STRAP_I,
  input wire logic        MODE_STRAP_ONE_I,
  input wire logic        MODE_STRAP_ZERO_I,
  input wire logic        SEQUENCER_RAM_ENABLE_REG_I,
  input wire logic        RAM_WE_I,
  input wire logic [3:0]  RAM_ADDR_I,
  input wire logic [15:0] RAM_RDATA_O,
  input wire logic        FW_READY_O,
  input wire logic        USER_MODE_O,
  // commands and flash port
  input wire logic        CMD_VALID_I,
  input wire logic        CMD_WORD_I,
  input wire logic        CMD_ERR_O,
  input wire logic        FL_DONE_I,
  input wire logic        FL_ERASE_O,
  input wire logic        FL_LOAD_O,
  input wire logic        FL_PROG_O,
  input wire logic [19:0] FL_ADDR_O,
  input wire logic        BUSY_O,
  // staging
  input wire logic        STAGE_SEL_O,
  input wire logic [1:0]  STAGE_FULL_O
);
  logic [7:0] ld_cnt_q;
  logic [7:0] ld_cnt_d;
  // loads seen since the last program strobe
  assign ld_cnt_d = FL_PROG_O ? 8'h00 : ld_cnt_q + {7'h00, FL_LOAD_O};
  always @(posedge CLK_I) ld_cnt_q <= RESET_I ? 8'h00 : ld_cnt_d;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);
  ram_block_a: assert property (
    !SEQUENCER_RAM_ENABLE_REG_I |=> RAM_RDATA_O == 16'h0000)
    else $error("working ram readable while disabled");
  fw_ready_a: assert property (
    RAM_WE_I && SEQUENCER_RAM_ENABLE_REG_I && RAM_ADDR_I == 4'hF
    |=> FW_READY_O) else $error("firmware ready not set");
  user_mode_a: assert property (
    (FLASH_WRITE_ENABLE_STRAP_I && MODE_STRAP_ONE_I && !MODE_STRAP_ZERO_I)
    [*5] |-> USER_MODE_O) else $error("user mode not seen");
  erase_busy_a: assert property (FL_ERASE_O |-> BUSY_O)
    else $error("erase strobe while not busy");
  busy_fall_a: assert property (
    $fell(BUSY_O) |-> $past(FL_DONE_I) || $past(FL_DONE_I, 2))
    else $error("busy fell without flash done");
  page_size_a: assert property (
    FL_PROG_O |-> ld_cnt_q == 8'h80 && FL_ADDR_O[7:0] == 8'h00)
    else $error("program not of one aligned page");
  erase_base_a: assert property (FL_ERASE_O |->
    ((FL_ADDR_O < 20'h1_0000) ? FL_ADDR_O[12:0] == 13'h0000 :
     (FL_ADDR_O < 20'hA_0000) ? FL_ADDR_O[15:0] == 16'h0000 :
     (FL_ADDR_O[16:0] == 17'h0_0000 && FL_ADDR_O <= 20'hE_0000)))
    else $error("erase address is not a block base");
  sel_swap_a: assert property ($changed(STAGE_SEL_O) |->
    $past(STAGE_FULL_O) == (STAGE_SEL_O ? 2'h2 : 2'h1))
    else $error("role flag swapped with wrong bank state");
  byte_err_a: assert property (
    CMD_VALID_I && !CMD_WORD_I |=> CMD_ERR_O)
    else $error("byte command not refused");
  erase_seen_c: cover property (FL_ERASE_O ##1 BUSY_O);
  prog_seen_c: cover property (FL_PROG_O);
  swap_seen_c: cover property ($rose(STAGE_SEL_O));
endmodule // fsq_monitor
bind fsq_top fsq_monitor fsq_monitor_i (
  .CLK_I(CLK_I), .RESET_I(RESET_I),
  .FLASH_WRITE_ENABLE_STRAP_I(FLASH_WRITE_ENABLE_STRAP_I),
  .MODE_STRAP_ONE_I(MODE_STRAP_ONE_I), .MODE_STRAP_ZERO_I(MODE_STRAP_ZERO_I),
  .SEQUENCER_RAM_ENABLE_REG_I(SEQUENCER_RAM_ENABLE_REG_I),
  .RAM_WE_I(RAM_WE_I), .RAM_ADDR_I(RAM_ADDR_I), .RAM_RDATA_O(RAM_RDATA_O),
  .FW_READY_O(FW_READY_O), .USER_MODE_O(USER_MODE_O),
  .CMD_VALID_I(CMD_VALID_I), .CMD_WORD_I(CMD_WORD_I), .CMD_ERR_O(CMD_ERR_O),
  .FL_DONE_I(FL_DONE_I), .FL_ERASE_O(FL_ERASE_O), .FL_LOAD_O(FL_LOAD_O),
  .FL_PROG_O(FL_PROG_O), .FL_ADDR_O(FL_ADDR_O), .BUSY_O(BUSY_O),
  .STAGE_SEL_O(STAGE_SEL_O), .STAGE_FULL_O(STAGE_FULL_O)
);
`default_nettype wire

// *** bench/fsq_flash_model.sv ***
// fsq_flash_model.sv: flash array model answering erase and program
`timescale 1ns/1ps
`default_nettype none
module fsq_flash_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // operation strobes and latency
  input  wire logic       erase_i,
  input  wire logic       prog_i,
  input  wire logic [7:0] lat_i,
  // completion
  output var  logic       done_o
);
  logic [7:0] cnt_q;
  logic       run_q;
  // one done pulse per operation, lat_i + 1 cycles after the edge that samples its strobe
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      run_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (erase_i | prog_i) begin
      run_q <= 1'b1;
      cnt_q <= lat_i;
    end else if (run_q && cnt_q == 8'h00) begin
      run_q <= 1'b0;
      done_o <= 1'b1;
    end else if (run_q) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule // fsq_flash_model
`default_nettype wire

// *** bench/tb_fsq_top.sv ***
// tb_fsq_top.sv: self-checking bench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fsq_regs.vh"
module tb_fsq_top;
  logic CLK_I = 1'b0, RESET_I = 1'b1, CE_I = 1'b1, RAM_WE_I = 1'b0;
  logic FLASH_WRITE_ENABLE_STRAP_I = 1'b1, MODE_STRAP_ONE_I = 1'b1;
  logic MODE_STRAP_ZERO_I = 1'b0, SEQUENCER_RAM_ENABLE_REG_I = 1'b0;
  logic CMD_VALID_I = 1'b0, CMD_WORD_I = 1'b1, CMD_ERR_CLR_I = 1'b0;
  logic JOB_ERASE_I = 1'b0, JOB_PROG_I = 1'b0, DL_VALID_I = 1'b0;
  logic BUF_BASE_WE_I = 1'b0, FL_DONE_I;
  logic [3:0]  RAM_ADDR_I = 4'h0;
  logic [15:0] RAM_WDATA_I = 16'h0000, CMD_DATA_I = 16'h0000;
  logic [15:0] DL_DATA_I = 16'h0000, RAM_RDATA_O, BUF_RD_DATA_O, FL_DATA_O;
  logic [7:0]  ERASE_FIRST_I = 8'h00, ERASE_COUNT_I = 8'h00, lat = 8'h01;
  logic [31:0] CMD_ADDR_I = 32'h0000_0000, WR_START_I = 32'h0000_0000;
  logic [31:0] WR_COUNT_I = 32'h0000_0000, BUF_RD_ADDR_I = 32'h0000_0000;
  logic [31:0] BUF_A_BASE_I = 32'h0000_0000, BUF_B_BASE_I = 32'h0000_0000;
  logic        DL_READY_O, FL_ERASE_O, FL_LOAD_O, FL_PROG_O, BUSY_O;
  logic        CMD_ERR_O, USER_MODE_O, FW_READY_O, STAGE_SEL_O, JOB_DONE_O;
  logic [1:0]  STAGE_FULL_O;
  logic [19:0] FL_ADDR_O, er_a, pg_a, fa;
  logic [19:0] eb [3] = '{20'h0_E000, 20'h2_0000, 20'hC_0000};
  integer      error_cnt = 0, n_tests = 0, n_er = 0, n_pg = 0, n_jd = 0;
  integer      i;
  fsq_top fsq_top_i (
    .CLK_I(CLK_I), .RESET_I(RESET_I), .CE_I(CE_I),
    .FLASH_WRITE_ENABLE_STRAP_I(FLASH_WRITE_ENABLE_STRAP_I),
    .MODE_STRAP_ONE_I(MODE_STRAP_ONE_I), .MODE_STRAP_ZERO_I(MODE_STRAP_ZERO_I),
    .SEQUENCER_RAM_ENABLE_REG_I(SEQUENCER_RAM_ENABLE_REG_I),
    .RAM_WE_I(RAM_WE_I), .RAM_ADDR_I(RAM_ADDR_I), .RAM_WDATA_I(RAM_WDATA_I),
    .RAM_RDATA_O(RAM_RDATA_O), .CMD_VALID_I(CMD_VALID_I),
    .CMD_ADDR_I(CMD_ADDR_I), .CMD_DATA_I(CMD_DATA_I), .CMD_WORD_I(CMD_WORD_I),
    .CMD_ERR_CLR_I(CMD_ERR_CLR_I), .JOB_ERASE_I(JOB_ERASE_I),
    .ERASE_FIRST_I(ERASE_FIRST_I), .ERASE_COUNT_I(ERASE_COUNT_I),
    .JOB_PROG_I(JOB_PROG_I), .WR_START_I(WR_START_I), .WR_COUNT_I(WR_COUNT_I),
    .DL_VALID_I(DL_VALID_I), .DL_DATA_I(DL_DATA_I), .DL_READY_O(DL_READY_O),
    .BUF_BASE_WE_I(BUF_BASE_WE_I), .BUF_A_BASE_I(BUF_A_BASE_I),
    .BUF_B_BASE_I(BUF_B_BASE_I), .BUF_RD_ADDR_I(BUF_RD_ADDR_I),
    .BUF_RD_DATA_O(BUF_RD_DATA_O), .FL_DONE_I(FL_DONE_I),
    .FL_ERASE_O(FL_ERASE_O), .FL_LOAD_O(FL_LOAD_O), .FL_PROG_O(FL_PROG_O),
    .FL_ADDR_O(FL_ADDR_O), .FL_DATA_O(FL_DATA_O), .BUSY_O(BUSY_O),
    .CMD_ERR_O(CMD_ERR_O), .USER_MODE_O(USER_MODE_O), .FW_READY_O(FW_READY_O),
    .STAGE_SEL_O(STAGE_SEL_O), .STAGE_FULL_O(STAGE_FULL_O),
    .JOB_DONE_O(JOB_DONE_O)
  );
  fsq_flash_model fsq_flash_model_i (
    .clk_i(CLK_I), .rst_i(RESET_I), .erase_i(FL_ERASE_O),
    .prog_i(FL_PROG_O), .lat_i(lat), .done_o(FL_DONE_I)
  );
  initial begin
    forever #2.5 CLK_I = ~CLK_I;
  end
  // word pattern tied to its flash address
  function automatic logic [15:0] pat(input logic [19:0] a);
    pat = {6'h2A, a[10:1]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // wait for ready (s=1) or idle (s=0), then one more cycle
  task wt(input logic s, input integer n);
    integer k;
    for (k = 0; (s ? DL_READY_O : ~BUSY_O) !== 1'b1; k = k + 1) begin
      if (k == n) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %0t: wait timed out", $time);
        conclude;
      end else @(negedge CLK_I);
    end
    @(negedge CLK_I);
  endtask
  task cmd(input logic [31:0] a, input logic [15:0] d, input logic w);
    CMD_VALID_I = 1'b1;
    CMD_ADDR_I = a;
    CMD_DATA_I = d;
    CMD_WORD_I = w;
    @(negedge CLK_I);
    CMD_VALID_I = 1'b0;
    @(negedge CLK_I);
  endtask
  task clr;
    CMD_ERR_CLR_I = 1'b1;
    @(negedge CLK_I);
    CMD_ERR_CLR_I = 1'b0;
    @(negedge CLK_I);
    check(CMD_ERR_O, 1'b0);
  endtask
  // download words of flash range a up to e
  task page(input logic [19:0] a, input logic [19:0] e);
    logic [19:0] x;
    for (x = a; x < e; x = x + 20'h0_0002) begin
      DL_VALID_I = 1'b1;
      DL_DATA_I = pat(x);
      wt(1'b1, 4000);
    end
    DL_VALID_I = 1'b0;
  endtask
  task rd(input logic [31:0] a, input logic [15:0] e);
    BUF_RD_ADDR_I = a;
    @(negedge CLK_I);
    check(BUF_RD_DATA_O, e);
  endtask
  // flash port observer
  always @(negedge CLK_I) begin
    if (FL_ERASE_O === 1'b1) begin
      n_er = n_er + 1;
      er_a = FL_ADDR_O;
    end
    if (FL_PROG_O === 1'b1) begin
      n_pg = n_pg + 1;
      pg_a = FL_ADDR_O;
    end
    if (JOB_DONE_O === 1'b1) n_jd = n_jd + 1;
    if (FL_LOAD_O === 1'b1) check(FL_DATA_O, pat(FL_ADDR_O));
  end
  initial begin
    repeat (4) @(negedge CLK_I);
    RESET_I = 1'b0;
    check(DL_READY_O, 1'b1);
    check(STAGE_SEL_O, 1'b0);
    repeat (4) @(negedge CLK_I);
    check(USER_MODE_O, 1'b1);
    cmd(`FSQ_ALIAS_OFS, `FSQ_CMD_ERASE, 1'b1);
    check(CMD_ERR_O, 1'b1);
    clr;
    for (i = 0; i < 2; i = i + 1) begin
      SEQUENCER_RAM_ENABLE_REG_I = i[0];
      for (fa = 20'h0_0000; fa < 20'h0_0010; fa = fa + 20'h0_0001) begin
        RAM_ADDR_I = fa[3:0];
        RAM_WDATA_I = 16'h5A00 + fa[15:0];
        RAM_WE_I = 1'b1;
        @(negedge CLK_I);
      end
      RAM_WE_I = 1'b0;
      RAM_ADDR_I = 4'h3;
      @(negedge CLK_I);
      check(RAM_RDATA_O, i ? 16'h5A03 : 16'h0000);
      check(FW_READY_O, i[0]);
    end
    for (i = 0; i < 3; i = i + 1) begin
      lat = i ? 8'h28 : 8'h01;
      cmd(`FSQ_ALIAS_OFS + 32'h000F_FFFE, `FSQ_CMD_ERASE, 1'b1);
      cmd(`FSQ_ALIAS_OFS + {12'h000, eb[i]} + 32'h0000_1F00,
          `FSQ_CMD_EXEC, 1'b1);
      wt(1'b0, 500);
      check(er_a, eb[i]);
      check(n_er, i + 1);
    end
    cmd(`FSQ_ALIAS_OFS, `FSQ_CMD_PROG, 1'b0);
    check(CMD_ERR_O, 1'b1);
    clr;
    cmd(`FSQ_ALIAS_OFS + 32'h0000_E000, `FSQ_CMD_PROG, 1'b1);
    cmd(`FSQ_ALIAS_OFS + 32'h0000_E000, `FSQ_SIZE_CODE, 1'b1);
    for (fa = 20'h0_E000; fa < 20'h0_E100; fa = fa + 20'h0_0002)
      cmd(`FSQ_ALIAS_OFS + {12'h000, fa}, pat(fa), 1'b1);
    wt(1'b0, 500);
    check(pg_a, 20'h0_E000);
    check(n_pg, 1);
    ERASE_FIRST_I = 8'h12;
    ERASE_COUNT_I = 8'h05;
    JOB_ERASE_I = 1'b1;
    @(negedge CLK_I);
    JOB_ERASE_I = 1'b0;
    @(negedge CLK_I);
    cmd(`FSQ_ALIAS_OFS, `FSQ_CMD_ERASE, 1'b1);
    check(CMD_ERR_O, 1'b1);
    wt(1'b0, 2000);
    check(n_er, 5);
    check(er_a, 20'hE_0000);
    check(n_jd, 1);
    clr;
    page(20'h2_0000, 20'h2_0100);
    repeat (4) @(negedge CLK_I);
    check(STAGE_SEL_O, 1'b1);
    check(STAGE_FULL_O, 2'h2);
    page(20'h2_0100, 20'h2_0208);
    check(DL_READY_O, 1'b0);
    check(STAGE_FULL_O, 2'h3);
    check(STAGE_SEL_O, 1'b1);
    rd(32'hFFF8_1102, pat(20'h2_0002));
    rd(32'hFFF8_1000, pat(20'h2_0100));
    CE_I = 1'b0;
    rd(32'hFFF8_1102, pat(20'h2_0100));
    CE_I = 1'b1;
    BUF_A_BASE_I = 32'hFFF8_2000;
    BUF_B_BASE_I = 32'hFFF8_3000;
    BUF_BASE_WE_I = 1'b1;
    @(negedge CLK_I);
    BUF_BASE_WE_I = 1'b0;
    rd(32'hFFF8_3004, pat(20'h2_0004));
    rd(32'hFFF8_1000, 16'h0000);
    WR_START_I = 32'h0002_0000;
    WR_COUNT_I = 32'h0000_0003;
    JOB_PROG_I = 1'b1;
    @(negedge CLK_I);
    JOB_PROG_I = 1'b0;
    page(20'h2_0208, 20'h2_0300);
    wt(1'b0, 5000);
    check(n_pg, 4);
    check(pg_a, 20'h2_0200);
    check(n_jd, 2);
    check(STAGE_SEL_O, 1'b1);
    check(STAGE_FULL_O, 2'h0);
    conclude;
  end
endmodule // tb_fsq_top
`default_nettype wire
